// ===== logic/eea_top.sv
// Error event aggregator: raw event flags, write-one-to-set masks, masked status views and four event outputs.
// Assumes synchronous event inputs, one clock pclk and an APB master that keeps the APB protocol.
`timescale 1ns/10ps
module eea_top
  import eea_pkg::*;
#(
  parameter int LINKS = EEA_LINKS,
  parameter int TXS_W = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [EEA_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire eea_link_a_t [LINKS-1:0] link_a_evt,
  input wire eea_link_b_t [LINKS-1:0] link_b_evt,
  input wire logic [LINKS-1:0][TXS_W-1:0] tx_fsm_state,
  input wire eea_common_t common_evt,
  input wire logic obsai_mode,
  output logic [EEA_EVENTS-1:0] error_event_out
);

  localparam int MCOPIES = 2 * LINKS + 2;

  logic [31:0] raw_a_r [LINKS];
  logic [31:0] raw_a_nxt [LINKS];
  logic [31:0] raw_b_r [LINKS];
  logic [31:0] raw_b_nxt [LINKS];
  logic [31:0] raw_c_r;
  logic [31:0] raw_c_nxt;
  logic [TXS_W-1:0] txs_prev_r [LINKS];
  logic [31:0] mask_a_r [MCOPIES];
  logic [31:0] mask_a_nxt [MCOPIES];
  logic [31:0] mask_b_r [MCOPIES];
  logic [31:0] mask_b_nxt [MCOPIES];
  logic [31:0] mask_c_r [EEA_EVENTS];
  logic [31:0] mask_c_nxt [EEA_EVENTS];
  logic [31:0] prdata_r;
  logic [31:0] prdata_nxt;
  logic pready_r;
  logic pready_nxt;
  logic pslverr_r;
  logic pslverr_nxt;
  logic [EEA_EVENTS-1:0] evt_r;
  logic [EEA_EVENTS-1:0] evt_nxt;

  logic dec_cmn;
  logic dec_ok;
  logic [1:0] dec_ev;
  logic [2:0] dec_link;
  logic [1:0] dec_sel;
  int dec_idx;
  logic access;
  logic wr_fire;
  logic [31:0] raw_or_a;
  logic [31:0] raw_or_b;
  logic [31:0] rd_val;

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign error_event_out = evt_r;

  // Address decode; status registers exist only as masked views onto shared raw storage, while each mask register has storage of its own.
  always_comb begin
    dec_cmn = paddr[EEA_CMN_BIT];
    dec_ev = dec_cmn ? paddr[EEA_CMN_EV_LSB +: 2] : paddr[EEA_EV_LSB +: 2];
    dec_link = paddr[EEA_LINK_LSB +: 3];
    dec_sel = paddr[EEA_SEL_LSB +: 2];
    if (dec_cmn) begin
      dec_ok = (paddr[11] == 1'b0) && (paddr[9:5] == 5'h00) && (paddr[1:0] == 2'h0);
      dec_idx = 0;
    end else if (dec_ev < 2'h2) begin
      dec_ok = (paddr[11] == 1'b0) && (paddr[7] == 1'b0) && (int'(dec_link) < LINKS) && (paddr[1:0] == 2'h0);
      dec_idx = int'(dec_ev) * LINKS + int'(dec_link);
    end else begin
      dec_ok = (paddr[11] == 1'b0) && (paddr[7] == 1'b0) && (dec_link == 3'h0) && (paddr[1:0] == 2'h0);
      dec_idx = 2 * LINKS + int'(dec_ev) - 2;
    end
  end

  assign access = psel && penable && !pready_r;
  assign wr_fire = psel && penable && pready_r && pwrite && dec_ok;

  // Outputs 2 and 3 each have a single copy, and that copy watches the events of every link.
  always_comb begin
    raw_or_a = '0;
    raw_or_b = '0;
    for (int l = 0; l < LINKS; l++) begin
      raw_or_a = raw_or_a | raw_a_r[l];
      raw_or_b = raw_or_b | raw_b_r[l];
    end
  end

  // Read view of the addressed register.
  always_comb begin
    rd_val = '0;
    if (dec_ok) begin
      if (dec_cmn) begin
        if (paddr[EEA_CMN_MASK_BIT]) begin
          rd_val = mask_c_r[dec_ev];
        end else begin
          rd_val = raw_c_r & mask_c_r[dec_ev];
        end
      end else begin
        case (dec_sel)
          EEA_SEL_STAT_A: begin
            rd_val = (dec_ev < 2'h2 ? raw_a_r[dec_link] : raw_or_a) & mask_a_r[dec_idx];
          end
          EEA_SEL_STAT_B: begin
            rd_val = (dec_ev < 2'h2 ? raw_b_r[dec_link] : raw_or_b) & mask_b_r[dec_idx];
          end
          EEA_SEL_MASK_A: begin
            rd_val = mask_a_r[dec_idx];
          end
          default: begin
            rd_val = mask_b_r[dec_idx];
          end
        endcase
      end
    end
  end

  // APB slave: one wait cycle, data and error answer registered with pready.
  always_comb begin
    pready_nxt = access;
    prdata_nxt = prdata_r;
    pslverr_nxt = 1'b0;
    if (access) begin
      prdata_nxt = pwrite ? 32'h0000_0000 : rd_val;
      pslverr_nxt = !dec_ok;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_r <= 1'b0;
      prdata_r <= EEA_RESET_VAL;
      pslverr_r <= 1'b0;
    end else begin
      pready_r <= pready_nxt;
      prdata_r <= prdata_nxt;
      pslverr_r <= pslverr_nxt;
    end
  end

  // Per-link raw flags; an arriving event wins over a clear in the same cycle.
  for (genvar l = 0; l < LINKS; l++) begin : g_link
    logic [31:0] set_a;
    logic [31:0] set_b;
    logic [31:0] clr_a;
    logic [31:0] clr_b;
    logic hit;
    always_comb begin
      set_a = link_a_evt[l] & EEA_A_VALID;
      set_b = link_b_evt[l] & EEA_B_VALID;
      set_b[EEA_B_TX_CHANGE_BIT] = set_b[EEA_B_TX_CHANGE_BIT] || (tx_fsm_state[l] != txs_prev_r[l]);
      hit = wr_fire && !dec_cmn && ((dec_ev >= 2'h2) || (int'(dec_link) == l));
      clr_a = (hit && dec_sel == EEA_SEL_STAT_A) ? pwdata : 32'h0000_0000;
      clr_b = (hit && dec_sel == EEA_SEL_STAT_B) ? pwdata : 32'h0000_0000;
      raw_a_nxt[l] = ((raw_a_r[l] & ~clr_a) | set_a) & EEA_A_VALID;
      raw_b_nxt[l] = ((raw_b_r[l] & ~clr_b) | set_b) & EEA_B_VALID;
    end
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        raw_a_r[l] <= EEA_RESET_VAL;
        raw_b_r[l] <= EEA_RESET_VAL;
        txs_prev_r[l] <= '0;
      end else begin
        raw_a_r[l] <= raw_a_nxt[l];
        raw_b_r[l] <= raw_b_nxt[l];
        txs_prev_r[l] <= tx_fsm_state[l];
      end
    end
  end

  // Common raw flags; the field layout of the carrier places bits 25 to 0.
  always_comb begin
    logic [31:0] set_c;
    logic [31:0] clr_c;
    set_c = common_evt & EEA_C_VALID;
    clr_c = (wr_fire && dec_cmn && !paddr[EEA_CMN_MASK_BIT]) ? pwdata : 32'h0000_0000;
    if (!obsai_mode) begin
      set_c = set_c & ~EEA_C_OBSAI_ONLY;
    end
    raw_c_nxt = ((raw_c_r & ~clr_c) | set_c) & EEA_C_VALID;
  end

  // Masks only ever set; writes of zero leave them alone.
  always_comb begin
    for (int i = 0; i < MCOPIES; i++) begin
      mask_a_nxt[i] = mask_a_r[i];
      mask_b_nxt[i] = mask_b_r[i];
      if (wr_fire && !dec_cmn && dec_idx == i && dec_sel == EEA_SEL_MASK_A) begin
        mask_a_nxt[i] = mask_a_r[i] | (pwdata & EEA_A_VALID);
      end
      if (wr_fire && !dec_cmn && dec_idx == i && dec_sel == EEA_SEL_MASK_B) begin
        mask_b_nxt[i] = mask_b_r[i] | (pwdata & EEA_B_VALID);
      end
    end
    for (int e = 0; e < EEA_EVENTS; e++) begin
      mask_c_nxt[e] = mask_c_r[e];
      if (wr_fire && dec_cmn && paddr[EEA_CMN_MASK_BIT] && int'(dec_ev) == e) begin
        mask_c_nxt[e] = mask_c_r[e] | (pwdata & EEA_C_VALID);
      end
    end
  end

  // Event outputs gather every enabled raw flag of their own copy.
  always_comb begin
    evt_nxt = '0;
    for (int e = 0; e < 2; e++) begin
      for (int l = 0; l < LINKS; l++) begin
        evt_nxt[e] = evt_nxt[e] || |(raw_a_r[l] & mask_a_r[e * LINKS + l])
          || |(raw_b_r[l] & mask_b_r[e * LINKS + l]);
      end
    end
    for (int e = 2; e < EEA_EVENTS; e++) begin
      evt_nxt[e] = |(raw_or_a & mask_a_r[2 * LINKS + e - 2]) || |(raw_or_b & mask_b_r[2 * LINKS + e - 2]);
    end
    for (int e = 0; e < EEA_EVENTS; e++) begin
      evt_nxt[e] = evt_nxt[e] || |(raw_c_r & mask_c_r[e]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      raw_c_r <= EEA_RESET_VAL;
      evt_r <= '0;
      for (int i = 0; i < MCOPIES; i++) begin
        mask_a_r[i] <= EEA_RESET_VAL;
        mask_b_r[i] <= EEA_RESET_VAL;
      end
      for (int e = 0; e < EEA_EVENTS; e++) begin
        mask_c_r[e] <= EEA_RESET_VAL;
      end
    end else begin
      raw_c_r <= raw_c_nxt;
      evt_r <= evt_nxt;
      for (int i = 0; i < MCOPIES; i++) begin
        mask_a_r[i] <= mask_a_nxt[i];
        mask_b_r[i] <= mask_b_nxt[i];
      end
      for (int e = 0; e < EEA_EVENTS; e++) begin
        mask_c_r[e] <= mask_c_nxt[e];
      end
    end
  end

  // Checks on link 0, event outputs 0 and 3, the common copy and the bus handshake.
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic ev3_masks_zero;
  assign ev3_masks_zero = (mask_a_r[MCOPIES - 1] == '0) && (mask_b_r[MCOPIES - 1] == '0) && (mask_c_r[3] == '0);

  sequence s_link0_wr(logic [1:0] sel);
    wr_fire && !dec_cmn && dec_ev == 2'h0 && dec_link == 3'h0 && dec_sel == sel;
  endsequence

  sequence s_read_access;
    psel && penable && !pready_r && !pwrite;
  endsequence

  mask_set_a: assert property (s_link0_wr(EEA_SEL_MASK_A) |=>
    mask_a_r[0] == ($past(mask_a_r[0]) | ($past(pwdata) & EEA_A_VALID)))
    else $error("mask set write did not set the written bits");
  mask_hold_a: assert property ((($past(mask_a_r[0]) & ~mask_a_r[0]) == '0))
    else $error("a mask bit was cleared");
  stat_clear_a: assert property (s_link0_wr(EEA_SEL_STAT_A) ##0 (pwdata[16] && !link_a_evt[0][16]) |=>
    !raw_a_r[0][16])
    else $error("write one did not clear the status bit");
  set_wins_a: assert property (link_a_evt[0][16] |=> raw_a_r[0][16])
    else $error("arriving event was lost");
  route_out_a: assert property ((raw_a_r[0][16] && mask_a_r[0][16]) |=> error_event_out[0])
    else $error("enabled event did not reach output 0");
  masked_off_a: assert property (ev3_masks_zero |=> !error_event_out[3])
    else $error("output 3 high with all masks clear");
  tx_change_a: assert property ((tx_fsm_state[0] != txs_prev_r[0]) |=> raw_b_r[0][EEA_B_TX_CHANGE_BIT])
    else $error("transmit state change not flagged");
  obsai_gate_a: assert property ((!obsai_mode && !raw_c_r[17]) |=> !raw_c_r[17])
    else $error("bus write flag set outside OBSAI mode");
  rsvd_zero_a: assert property (s_read_access ##0 (dec_cmn && dec_ok) |=> (prdata_r & ~EEA_C_VALID) == '0)
    else $error("reserved common bits read nonzero");
  mask_read_a: assert property (s_read_access ##0 (dec_ok && !dec_cmn && dec_idx == 0 && dec_sel == EEA_SEL_MASK_A)
    |=> prdata_r == $past(mask_a_r[0]))
    else $error("mask read differs from live mask");
  stat_view_a: assert property (s_read_access ##0 (dec_ok && !dec_cmn && dec_idx == 0 && dec_sel == EEA_SEL_STAT_A)
    |=> prdata_r == ($past(raw_a_r[0]) & $past(mask_a_r[0])))
    else $error("masked status read is not raw AND mask");
  ready_pulse_a: assert property ((psel && penable && !pready_r) |=> pready_r ##1 !pready_r)
    else $error("pready not a single pulse after one wait");

  // Further checks on the common copy, the shared link copy, links 0 and LINKS - 1 and the bus answer.
  sequence s_cmn_wr(logic mask_sel, logic [1:0] ev);
    wr_fire && dec_cmn && paddr[EEA_CMN_MASK_BIT] == mask_sel && dec_ev == ev;
  endsequence

  sequence s_shared_wr(logic [1:0] sel);
    wr_fire && !dec_cmn && dec_ev == 2'h2 && dec_sel == sel;
  endsequence

  sequence s_bus_access(logic ok);
    psel && penable && !pready_r && dec_ok == ok;
  endsequence

  cmn_mask_set_a: assert property (s_cmn_wr(1'b1, 2'h3) |=>
    mask_c_r[3] == ($past(mask_c_r[3]) | ($past(pwdata) & EEA_C_VALID)))
    else $error("common mask set write did not set the written bits");
  cmn_clear_a: assert property (s_cmn_wr(1'b0, 2'h0) ##0 (pwdata[0] && !common_evt[0]) |=>
    !raw_c_r[0])
    else $error("write one did not clear the common status bit");
  cmn_set_wins_a: assert property (common_evt[0] |=> raw_c_r[0])
    else $error("arriving common event was lost");
  shared_clear_a: assert property (s_shared_wr(EEA_SEL_STAT_A) ##0 (pwdata[16] && !link_a_evt[1][16]) |=>
    !raw_a_r[1][16])
    else $error("shared copy write did not clear the flag of link 1");
  obsai_pass_a: assert property ((obsai_mode && common_evt[16]) |=> raw_c_r[16])
    else $error("bus read flag lost in OBSAI mode");
  cmn_route_a: assert property ((raw_c_r[0] && mask_c_r[2][0]) |=> error_event_out[2])
    else $error("enabled common event did not reach output 2");
  all_quiet_a: assert property ((raw_c_r == '0 && raw_or_a == '0 && raw_or_b == '0) |=>
    error_event_out == '0)
    else $error("event output high with no flag set");
  rsvd_raw_a: assert property (((raw_a_r[0] & ~EEA_A_VALID) | (raw_b_r[0] & ~EEA_B_VALID)) == '0)
    else $error("reserved raw flag set");
  cmn_view_a: assert property (s_read_access ##0 (dec_ok && dec_cmn && dec_ev == 2'h1)
    ##0 !paddr[EEA_CMN_MASK_BIT] |=> prdata_r == ($past(raw_c_r) & $past(mask_c_r[1])))
    else $error("common masked status read is not raw AND mask");
  unmapped_err_a: assert property (s_bus_access(1'b0) |=> pready_r && pslverr_r)
    else $error("unmapped access answered without error");
  mapped_ok_a: assert property (s_bus_access(1'b1) |=> pready_r && !pslverr_r)
    else $error("mapped access answered with error");
  wr_answer_a: assert property ((psel && penable && !pready_r && pwrite) |=> prdata_r == '0)
    else $error("write answer carried nonzero data");
  mask_b_ev1_a: assert property (wr_fire && !dec_cmn && dec_idx == 2 * LINKS - 1 && dec_sel == EEA_SEL_MASK_B |=>
    mask_b_r[2 * LINKS - 1] == ($past(mask_b_r[2 * LINKS - 1]) | ($past(pwdata) & EEA_B_VALID)))
    else $error("mask set B write on output 1 last link did not set the bits");
  shared_route_a: assert property ((raw_or_a[0] && mask_a_r[2 * LINKS][0]) |=> error_event_out[2])
    else $error("shared copy event did not reach output 2");
  mask_hold_c_a: assert property ((($past(mask_c_r[0]) & ~mask_c_r[0]) == '0))
    else $error("a common mask bit was cleared");
  tx_change_last_a: assert property ((tx_fsm_state[LINKS - 1] != txs_prev_r[LINKS - 1]) |=>
    raw_b_r[LINKS - 1][EEA_B_TX_CHANGE_BIT])
    else $error("transmit state change of the last link not flagged");

endmodule

// ===== logic/eea_pkg.sv
// Package for the error event aggregator: register map, field layouts and event carriers.
// Assumes a 32-bit APB slave with byte addresses and one aligned word per register.
package eea_pkg;

  localparam int EEA_LINKS = 6;
  localparam int EEA_EVENTS = 4;
  localparam int EEA_ADDR_W = 12;

  // Link registers: addr[9:8] event output, addr[6:4] link, addr[3:2] register select.
  localparam int EEA_EV_LSB = 8;
  localparam int EEA_LINK_LSB = 4;
  localparam int EEA_SEL_LSB = 2;
  localparam logic [1:0] EEA_SEL_STAT_A = 2'h0;
  localparam logic [1:0] EEA_SEL_STAT_B = 2'h1;
  localparam logic [1:0] EEA_SEL_MASK_A = 2'h2;
  localparam logic [1:0] EEA_SEL_MASK_B = 2'h3;

  // Common registers: addr[10] set, addr[4:3] event output, addr[2] selects mask over status.
  localparam int EEA_CMN_BIT = 10;
  localparam int EEA_CMN_EV_LSB = 3;
  localparam int EEA_CMN_MASK_BIT = 2;

  // Implemented bit positions; every other position is reserved and reads as zero.
  localparam logic [31:0] EEA_A_VALID = 32'h1f11_ffff;
  localparam logic [31:0] EEA_B_VALID = 32'h011f_370f;
  localparam logic [31:0] EEA_C_VALID = 32'h03ff_ff03;
  localparam logic [31:0] EEA_C_OBSAI_ONLY = 32'h0003_0000;
  localparam logic [31:0] EEA_RESET_VAL = 32'h0000_0000;
  localparam int EEA_B_TX_CHANGE_BIT = 0;

  typedef struct packed {
    logic [2:0] rsvd_hi;
    logic decoder_hyperframe_err;
    logic decoder_type_err;
    logic decoder_addr_err;
    logic decoder_sync_err;
    logic decoder_stamp_err;
    logic [2:0] rsvd_mid;
    logic converter_frame_err;
    logic [2:0] rsvd_lo;
    logic serializer_signal_loss;
    logic [15:0] receive_mac;
  } eea_link_a_t;

  typedef struct packed {
    logic [6:0] rsvd_hi;
    logic encoder_cword_err;
    logic [2:0] rsvd_mid;
    logic [4:0] data_buffer_dma;
    logic [1:0] rsvd_comb;
    logic [1:0] combiner_decombiner_fifo;
    logic rsvd_ag;
    logic [2:0] aggregator;
    logic [3:0] rsvd_lo;
    logic [3:0] transmit_mac;
  } eea_link_b_t;

  typedef struct packed {
    logic [5:0] rsvd_hi;
    logic pkt_out_illegal_write;
    logic capture_wrong_half_access;
    logic circ_out_bus_read_flag;
    logic circ_in_bus_write_flag;
    logic pkt_out_bus_read_flag;
    logic pkt_in_bus_write_flag;
    logic pkt_out_queue_overflow;
    logic pkt_out_list_error;
    logic pkt_out_bus_write_err;
    logic pkt_in_bus_read_err;
    logic err_queue_dma_underflow;
    logic [2:0] in_queue_dma_underflow;
    logic err_queue_dma_overflow;
    logic [2:0] in_queue_dma_overflow;
    logic [5:0] rsvd_lo;
    logic combiner_b_align_error;
    logic combiner_a_align_error;
  } eea_common_t;

endpackage

// ===== dv/eea_src.sv
// Event source model: registers the event vectors chosen by the bench onto the aggregator inputs.
// Assumes the bench holds en high for as many cycles as the events should stay asserted.
`timescale 1ns/10ps
module eea_src
  import eea_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic en,
  input wire logic [5:0][31:0] a_in,
  input wire logic [5:0][31:0] b_in,
  input wire logic [31:0] c_in,
  input wire logic [5:0][3:0] tx_in,
  output eea_link_a_t [5:0] link_a_evt,
  output eea_link_b_t [5:0] link_b_evt,
  output eea_common_t common_evt,
  output logic [5:0][3:0] tx_fsm_state
);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link_a_evt <= '0;
      link_b_evt <= '0;
      common_evt <= '0;
      tx_fsm_state <= '0;
    end else begin
      link_a_evt <= en ? a_in : '0;
      link_b_evt <= en ? b_in : '0;
      common_evt <= en ? c_in : '0;
      // The transmit state moves freely; each new value is a state change.
      tx_fsm_state <= tx_in;
    end
  end
endmodule

// ===== dv/tb_top.sv
// Self-checking bench for the error event aggregator with a behavioural register model.
// Assumes the package map: link address ev<<8|link<<4|sel<<2, common 0x400|ev<<3|mask<<2.
`timescale 1ns/10ps
module tb_top
  import eea_pkg::*;
;
  logic pclk, presetn, psel, penable, pwrite, en, obsai_mode, pready, pslverr;
  logic [EEA_ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, c_in, raw_c;
  logic [5:0][31:0] a_in, b_in;
  logic [5:0][3:0] tx_in, tx_old, tx_fsm_state;
  eea_link_a_t [5:0] link_a_evt;
  eea_link_b_t [5:0] link_b_evt;
  eea_common_t common_evt;
  logic [3:0] error_event_out;
  logic [31:0] raw_a[6], raw_b[6], ma[4][6], mb[4][6], mc[4];
  logic [31:0] rd;
  logic er;
  logic [11:0] bad[4];
  int fails, cmp_count, seed;

  always #5 pclk = ~pclk;

  eea_top #(.LINKS(6), .TXS_W(4)) uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .link_a_evt(link_a_evt), .link_b_evt(link_b_evt), .tx_fsm_state(tx_fsm_state), .common_evt(common_evt),
    .obsai_mode(obsai_mode), .error_event_out(error_event_out));
  eea_src src (.pclk(pclk), .presetn(presetn), .en(en), .a_in(a_in), .b_in(b_in), .c_in(c_in), .tx_in(tx_in),
    .link_a_evt(link_a_evt), .link_b_evt(link_b_evt), .common_evt(common_evt), .tx_fsm_state(tx_fsm_state));

  task automatic end_of_test();
    if (fails == 0 && cmp_count > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 20; n++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 20) begin
      fails++;
      end_of_test();
    end
  endtask

  function automatic logic [11:0] la(int ev, int l, int s);
    return 12'(ev * 256 + l * 16 + s * 4);
  endfunction

  function automatic logic [11:0] ca(int ev, int m);
    return 12'(1024 + ev * 8 + m * 4);
  endfunction

  function automatic logic [31:0] exp_l(int ev, int l, int s);
    logic [31:0] ra, rb;
    ra = raw_a[l];
    rb = raw_b[l];
    if (ev > 1) begin
      for (int k = 0; k < 6; k++) begin
        ra |= raw_a[k];
        rb |= raw_b[k];
      end
    end
    case (s)
      0: return ra & ma[ev][l];
      1: return rb & mb[ev][l];
      2: return ma[ev][l];
      default: return mb[ev][l];
    endcase
  endfunction

  function automatic logic [3:0] exp_out();
    logic [3:0] o;
    for (int ev = 0; ev < 4; ev++) begin
      o[ev] = |(raw_c & mc[ev]);
      for (int l = 0; l < (ev < 2 ? 6 : 1); l++) o[ev] |= (|exp_l(ev, l, 0)) | (|exp_l(ev, l, 1));
    end
    return o;
  endfunction

  function automatic logic [5:0][31:0] rnd6();
    logic [5:0][31:0] v;
    for (int k = 0; k < 6; k++) v[k] = $random(seed);
    return v;
  endfunction

  task automatic check_all();
    for (int ev = 0; ev < 4; ev++) begin
      for (int l = 0; l < (ev < 2 ? 6 : 1); l++) begin
        for (int s = 0; s < 4; s++) begin
          apb(1'b0, la(ev, l, s), 32'h0);
          chk("link reg", exp_l(ev, l, s), rd);
          chk("link slverr", 32'h0, {31'h0, er});
        end
      end
      for (int m = 0; m < 2; m++) begin
        apb(1'b0, ca(ev, m), 32'h0);
        chk("common reg", m ? mc[ev] : raw_c & mc[ev], rd);
      end
    end
    repeat (3) @(posedge pclk);
    chk("event out", {28'h0, exp_out()}, {28'h0, error_event_out});
  endtask

  task automatic lw(int ev, int l, int s, logic [31:0] d);
    apb(1'b1, la(ev, l, s), d);
    for (int k = 0; k < 6; k++) begin
      if (s == 0 && (ev > 1 || k == l)) raw_a[k] &= ~d;
      if (s == 1 && (ev > 1 || k == l)) raw_b[k] &= ~d;
    end
    if (s == 2) ma[ev][l] |= d & EEA_A_VALID;
    if (s == 3) mb[ev][l] |= d & EEA_B_VALID;
  endtask

  task automatic cw(int ev, int m, logic [31:0] d);
    apb(1'b1, ca(ev, m), d);
    if (m == 1) mc[ev] |= d & EEA_C_VALID;
    else raw_c &= ~d;
  endtask

  task automatic fire(logic [5:0][31:0] a, logic [5:0][31:0] b, logic [31:0] c, logic [5:0][3:0] tx, logic ob);
    @(posedge pclk);
    a_in <= a;
    b_in <= b;
    c_in <= c;
    tx_in <= tx;
    obsai_mode <= ob;
    en <= 1'b1;
    @(posedge pclk);
    en <= 1'b0;
    for (int k = 0; k < 6; k++) begin
      raw_a[k] |= a[k] & EEA_A_VALID;
      raw_b[k] |= (b[k] & EEA_B_VALID) | {31'h0, tx[k] != tx_old[k]};
    end
    raw_c |= c & EEA_C_VALID & (ob ? 32'hffff_ffff : ~EEA_C_OBSAI_ONLY);
    tx_old = tx;
  endtask

  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    en = 1'b0;
    obsai_mode = 1'b0;
    a_in = '0;
    b_in = '0;
    c_in = '0;
    tx_in = '0;
    tx_old = '0;
    raw_c = '0;
    mc = '{default: '0};
    raw_a = '{default: '0};
    raw_b = '{default: '0};
    ma = '{default: '{default: '0}};
    mb = '{default: '{default: '0}};
    bad = '{12'h800, 12'h210, 12'h068, 12'h218};
    fails = 0;
    cmp_count = 0;
    seed = 30;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    check_all();
    for (int r = 0; r < 2; r++) begin
      for (int ev = 0; ev < 4; ev++) begin
        for (int l = 0; l < (ev < 2 ? 6 : 1); l++) begin
          lw(ev, l, 2, $random(seed));
          lw(ev, l, 3, $random(seed));
        end
        cw(ev, 1, $random(seed));
      end
      check_all();
    end
    for (int t = 0; t < 6; t++) begin
      fire(rnd6(), rnd6(), $random(seed), 24'($random(seed)), t[0]);
      check_all();
      for (int l = 0; l < (t % 4 < 2 ? 6 : 1); l++) begin
        lw(t % 4, l, 0, $random(seed));
        lw(t % 4, l, 1, $random(seed));
      end
      cw(t % 4, 0, $random(seed));
      check_all();
    end
    lw(0, 0, 2, 32'h1);
    a_in <= 192'h1;
    b_in <= '0;
    c_in <= '0;
    // The event is seen by the design only at the edge where the clear write lands.
    fork
      lw(0, 0, 0, 32'h1);
      begin
        repeat (2) @(posedge pclk);
        en <= 1'b1;
        @(posedge pclk);
        en <= 1'b0;
      end
    join
    raw_a[0] |= 32'h1;
    check_all();
    foreach (bad[i]) begin
      apb(1'b1, bad[i], 32'hffff_ffff);
      chk("slverr wr", 32'h1, {31'h0, er});
      apb(1'b0, bad[i], 32'h0);
      chk("slverr rd", 32'h1, {31'h0, er});
      chk("unmapped data", 32'h0, rd);
    end
    check_all();
    end_of_test();
  end
endmodule
